// File: tlic_defs.svh
// tlic_defs.svh: constants of the two-level interrupt controller
// assumes: included by bare name from the package and design files
`ifndef TLIC_DEFS_SVH
`define TLIC_DEFS_SVH

`define TLIC_NUM_SRC        16
`define TLIC_SRC_W          4
`define TLIC_PC_W           16
`define TLIC_VEC_W          8
`define TLIC_CNT_W          3

`define TLIC_RESET_PC       16'h0000
`define TLIC_VEC_OFFSET     16'h0000
`define TLIC_VEC_STRIDE     16'h0002

`define TLIC_NMI_VEC        8'h01
`define TLIC_FIRST_SRC_VEC  8'h02
`define TLIC_CVT_L1_VEC     8'h02
`define TLIC_CVT_L0_VEC     8'h03
`define TLIC_HLV_RESET      8'h00

`define TLIC_CLK_PERIOD_NS  5
`define TLIC_PUSH_CYC       3'h2
`define TLIC_JUMP_CYC       3'h3
`define TLIC_WAKE_CYC       3'h5
`define TLIC_POP_CYC        3'h4
`define TLIC_POP_WIDE_CYC   3'h5

`endif

// File: tlic_pkg.sv
// tlic_pkg.sv: types shared by the interrupt controller modules
// assumes: tlic_defs.svh on the include path
`default_nettype none
`include "tlic_defs.svh"

package tlic_pkg;

  typedef enum logic [2:0] {
    TLIC_ST_IDLE = 3'b000,
    TLIC_ST_WAKE = 3'b001,
    TLIC_ST_PUSH = 3'b010,
    TLIC_ST_JUMP = 3'b011,
    TLIC_ST_POP  = 3'b100
  } tlic_state_t;

  // one bit per execution level, used for status and for captured grants
  typedef struct packed {
    logic nmi;
    logic lvl1;
    logic normal_priority_level;
  } tlic_level_t;

  typedef struct packed {
    logic                     valid;
    logic [`TLIC_SRC_W-1:0]   idx;
  } tlic_grant_t;

endpackage : tlic_pkg

`default_nettype wire

// File: tlic_l0_arbiter.sv
// tlic_l0_arbiter.sv: level 0 request picker, fixed or rotating priority
// assumes: single clock domain, purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "tlic_defs.svh"

module tlic_l0_arbiter (
  input  wire logic [`TLIC_NUM_SRC-1:0] req,
  input  wire logic [`TLIC_SRC_W-1:0]   last_idx,
  input  wire logic                     rotate_en,
  output tlic_pkg::tlic_grant_t         grant
);

  // lowest index at or after start wins, wrapping round
  function automatic tlic_pkg::tlic_grant_t pick(
    input logic [`TLIC_NUM_SRC-1:0] r,
    input logic [`TLIC_SRC_W-1:0]   start
  );
    tlic_pkg::tlic_grant_t g;
    logic [`TLIC_SRC_W-1:0] j;
    g = '0;
    for (int k = `TLIC_NUM_SRC - 1; k >= 0; k--) begin
      j = start + `TLIC_SRC_W'(k);
      if (r[j]) begin
        g.valid = 1'b1;
        g.idx   = j;
      end
    end
    return g;
  endfunction : pick

  logic [`TLIC_SRC_W-1:0] start;

  // last granted source drops to lowest priority
  assign start = rotate_en ? `TLIC_SRC_W'(last_idx + `TLIC_SRC_W'(1)) : '0;
  assign grant = pick(req, start);

endmodule : tlic_l0_arbiter

`default_nettype wire

// File: tlic_cycle_timer.sv
// tlic_cycle_timer.sv: down counter timing each phase of entry and return
// assumes: start is a one-cycle pulse, hold freezes the count
`timescale 1ns/10ps
`default_nettype none
`include "tlic_defs.svh"

module tlic_cycle_timer (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire logic                   start,
  input  wire logic [`TLIC_CNT_W-1:0] len,
  input  wire logic                   hold,
  output logic                        last
);

  logic [`TLIC_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (hold) begin
      cnt_q <= cnt_q;
    end else if (start) begin
      cnt_q <= len;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - `TLIC_CNT_W'(1);
    end
  end

  // high in the final cycle of the phase
  assign last = (cnt_q == `TLIC_CNT_W'(1)) && !hold;

endmodule : tlic_cycle_timer

`default_nettype wire

// File: tlic_core_request_arbiter.sv
// tlic_core_request_arbiter.sv: two-level interrupt controller top
// assumes: core gives an instruction boundary pulse, a decoded return
// pulse and its global enable level; all inputs synchronous to MCLK
`timescale 1ns/10ps
`default_nettype none
`include "tlic_defs.svh"

// Overview of operation
// - requests win against running level or stay pending until they do
// - acknowledge loads program counter with the vector entry address
// - one instruction runs after return or enable before next service
// - level status tracked so return restores the previous level
// - level status never pushed to memory, kept in hardware only
// - all sources level 0 after reset; one vector may be level 1
// - level 1 vector chosen by the high level vector field
// - level 1 preempts a level 0 handler, which resumes afterwards
// - fixed mode grants lowest vector address among level 0 requests
// - optional rotating priority for level 0 enabled by control bit
// - in rotating mode last acknowledged level 0 gets lowest priority
// - maskable requests taken only while global enable is 1
// - acknowledge leaves the global enable bit unchanged
// - only request lines enabled by their peripheral are considered
// - handler entry never clears the peripheral request flag
// - reset starts at 0x0000; vector base set by vector base select
// - entry: finish instruction, two cycles push, three cycles jump
// - request during multicycle instruction waits for its completion
// - wake from sleep adds five cycles plus the sleep start-up time
// - return pops program counter in four or five cycles
// - runs during run-time debug, stops while debugger halts core
// - compact table: non-maskable vector 1, level 1 vector 2, level 0 3
// - non-maskable ignores global enable, never preempted
module tlic_core_request_arbiter #(
  parameter bit WIDE_PC = 1'b0
) (
  input  wire logic                     MCLK,
  input  wire logic                     RST_B,
  input  wire logic [`TLIC_NUM_SRC-1:0] PERIPHERAL_REQUEST_FLAGS,
  input  wire logic [`TLIC_NUM_SRC-1:0] PERIPHERAL_REQUEST_CONTROL,
  input  wire logic                     NMI_REQUEST,
  input  wire logic                     GLOBAL_ENABLE,
  input  wire logic                     INSTR_DONE,
  input  wire logic                     RETURN_FROM_HANDLER,
  input  wire logic                     SLEEPING,
  input  wire logic                     STARTUP_DONE,
  input  wire logic                     DEBUG_HALT,
  input  wire logic                     VECTOR_BASE_SELECT,
  input  wire logic                     COMPACT_TABLE_ENABLE,
  input  wire logic                     ROTATING_PRIORITY_ENABLE,
  input  wire logic [`TLIC_VEC_W-1:0]   HIGH_LEVEL_VECTOR,
  input  wire logic [`TLIC_PC_W-1:0]    APP_START,
  output logic                          PC_LOAD,
  output logic [`TLIC_PC_W-1:0]         PC_VALUE,
  output logic                          CORE_HOLD,
  output logic                          STACK_PUSH,
  output logic                          STACK_POP,
  output logic                          WAKE_REQUEST,
  output logic [`TLIC_VEC_W-1:0]        ACK_VECTOR,
  output logic                          NMI_EXEC,
  output logic                          LEVEL1_EXEC,
  output logic                          LEVEL0_EXEC
);

  function automatic logic [`TLIC_PC_W-1:0] vec_addr(
    input logic [`TLIC_PC_W-1:0]  base,
    input logic [`TLIC_VEC_W-1:0] vec
  );
    return `TLIC_PC_W'(base + `TLIC_PC_W'(vec) * `TLIC_VEC_STRIDE);
  endfunction : vec_addr

  function automatic logic [`TLIC_VEC_W-1:0] src_vec(input logic [`TLIC_SRC_W-1:0] idx);
    return `TLIC_VEC_W'(`TLIC_FIRST_SRC_VEC + `TLIC_VEC_W'(idx));
  endfunction : src_vec

  tlic_pkg::tlic_state_t state_q;
  tlic_pkg::tlic_state_t state_d;
  tlic_pkg::tlic_level_t exec_q;
  tlic_pkg::tlic_level_t kind_q;
  tlic_pkg::tlic_level_t kind_d;
  tlic_pkg::tlic_grant_t l0_grant;

  logic [`TLIC_SRC_W-1:0]   last_idx_q;
  logic [`TLIC_SRC_W-1:0]   grant_idx_q;
  logic [`TLIC_SRC_W-1:0]   grant_idx_d;
  logic [`TLIC_VEC_W-1:0]   vec_q;
  logic [`TLIC_VEC_W-1:0]   vec_d;
  logic [`TLIC_NUM_SRC-1:0] live_req;
  logic [`TLIC_NUM_SRC-1:0] l0_req;
  logic [`TLIC_NUM_SRC-1:0] l1_hit;
  logic                     l1_req;
  logic                     nmi_ok;
  logic                     l1_ok;
  logic                     l0_ok;
  logic                     any_win;
  logic                     boundary;
  logic                     take;
  logic                     holdoff_q;
  logic                     ge_prev_q;
  logic                     timer_start;
  logic [`TLIC_CNT_W-1:0]   timer_len;
  logic                     timer_last;
  logic                     run;
  logic [`TLIC_PC_W-1:0]    base;

  // halted debugger freezes sequencing, timer and level state; run-time debug runs normally
  assign run = !DEBUG_HALT;

  // flags only read, never cleared here disabled lines dropped
  assign live_req = PERIPHERAL_REQUEST_FLAGS & PERIPHERAL_REQUEST_CONTROL;

  // at most one source matches the high level vector, everything else is level 0
  always_comb begin
    for (int i = 0; i < `TLIC_NUM_SRC; i++) begin
      l1_hit[i] = (HIGH_LEVEL_VECTOR == src_vec(`TLIC_SRC_W'(i)));
    end
  end
  assign l0_req = live_req & ~l1_hit;
  assign l1_req = |(live_req & l1_hit);

  tlic_l0_arbiter u_l0_arbiter (
    .req       (l0_req),
    .last_idx  (last_idx_q),
    .rotate_en (ROTATING_PRIORITY_ENABLE),
    .grant     (l0_grant)
  );

  // compare each level against the one executing
  assign nmi_ok = NMI_REQUEST && !exec_q.nmi;
  assign l1_ok  = GLOBAL_ENABLE && l1_req && !exec_q.lvl1 && !exec_q.nmi;
  assign l0_ok  = GLOBAL_ENABLE && l0_grant.valid && !exec_q.normal_priority_level
                  && !exec_q.lvl1 && !exec_q.nmi;
  assign any_win = nmi_ok || l1_ok || l0_ok;

  // entry starts only once the running instruction has finished
  assign boundary = (INSTR_DONE && !holdoff_q && !(GLOBAL_ENABLE && !ge_prev_q))
                    || (SLEEPING && STARTUP_DONE);
  assign take     = run && (state_q == tlic_pkg::TLIC_ST_IDLE) && any_win && boundary;

  always_comb begin
    kind_d      = kind_q;
    vec_d       = vec_q;
    grant_idx_d = grant_idx_q;
    if (take) begin
      kind_d      = '0;
      grant_idx_d = l0_grant.idx;
      if (nmi_ok) begin
        kind_d.nmi = 1'b1;
        vec_d      = `TLIC_NMI_VEC;
      end else if (l1_ok) begin
        kind_d.lvl1 = 1'b1;
        vec_d       = COMPACT_TABLE_ENABLE ? `TLIC_CVT_L1_VEC : HIGH_LEVEL_VECTOR;
      end else begin
        kind_d.normal_priority_level = 1'b1;
        vec_d       = COMPACT_TABLE_ENABLE ? `TLIC_CVT_L0_VEC
                                           : src_vec(l0_grant.idx);
      end
    end
  end

  // entry and return sequencing
  always_comb begin
    state_d     = state_q;
    timer_start = 1'b0;
    timer_len   = '0;
    if (run) begin
      unique case (state_q)
        tlic_pkg::TLIC_ST_IDLE: begin
          if (take && SLEEPING) begin
            state_d     = tlic_pkg::TLIC_ST_WAKE;
            timer_start = 1'b1;
            timer_len   = `TLIC_WAKE_CYC;
          end else if (take) begin
            state_d     = tlic_pkg::TLIC_ST_PUSH;
            timer_start = 1'b1;
            timer_len   = `TLIC_PUSH_CYC;
          end else if (RETURN_FROM_HANDLER) begin
            state_d     = tlic_pkg::TLIC_ST_POP;
            timer_start = 1'b1;
            timer_len   = WIDE_PC ? `TLIC_POP_WIDE_CYC : `TLIC_POP_CYC;
          end
        end
        tlic_pkg::TLIC_ST_WAKE: begin
          if (timer_last) begin
            state_d     = tlic_pkg::TLIC_ST_PUSH;
            timer_start = 1'b1;
            timer_len   = `TLIC_PUSH_CYC;
          end
        end
        tlic_pkg::TLIC_ST_PUSH: begin
          if (timer_last) begin
            state_d     = tlic_pkg::TLIC_ST_JUMP;
            timer_start = 1'b1;
            timer_len   = `TLIC_JUMP_CYC;
          end
        end
        tlic_pkg::TLIC_ST_JUMP: begin
          if (timer_last) begin
            state_d = tlic_pkg::TLIC_ST_IDLE;
          end
        end
        tlic_pkg::TLIC_ST_POP: begin
          if (timer_last) begin
            state_d = tlic_pkg::TLIC_ST_IDLE;
          end
        end
        default: begin
          state_d = tlic_pkg::TLIC_ST_IDLE;
        end
      endcase
    end
  end

  tlic_cycle_timer u_cycle_timer (
    .clk   (MCLK),
    .rst_b (RST_B),
    .start (timer_start),
    .len   (timer_len),
    .hold  (DEBUG_HALT),
    .last  (timer_last)
  );

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= tlic_pkg::TLIC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // captured grant held for the whole entry
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      kind_q      <= '0;
      vec_q       <= '0;
      grant_idx_q <= '0;
    end else begin
      kind_q      <= kind_d;
      vec_q       <= vec_d;
      grant_idx_q <= grant_idx_d;
    end
  end

  // rotation pointer moves when a level 0 jump begins
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      last_idx_q <= '0;
    end else if (run && state_q == tlic_pkg::TLIC_ST_PUSH && timer_last && kind_q.normal_priority_level) begin
      last_idx_q <= grant_idx_q;
    end
  end

  // level status lives only here, set at jump, cleared by return
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      exec_q <= '0;
    end else if (run && state_q == tlic_pkg::TLIC_ST_PUSH && timer_last) begin
      exec_q <= exec_q | kind_q;
    end else if (run && state_q == tlic_pkg::TLIC_ST_POP && timer_last) begin
      if (exec_q.nmi) begin
        exec_q.nmi <= 1'b0;
      end else if (exec_q.lvl1) begin
        exec_q.lvl1 <= 1'b0;
      end else begin
        exec_q.normal_priority_level <= 1'b0;
      end
    end
  end

  // one instruction after return, jump or enable rise before service
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ge_prev_q <= 1'b0;
      holdoff_q <= 1'b0;
    end else if (run) begin
      ge_prev_q <= GLOBAL_ENABLE;
      if ((state_q == tlic_pkg::TLIC_ST_POP || state_q == tlic_pkg::TLIC_ST_JUMP)
          && timer_last) begin
        holdoff_q <= 1'b1;
      end else if (GLOBAL_ENABLE && !ge_prev_q) begin
        holdoff_q <= 1'b1;
      end else if (INSTR_DONE || SLEEPING) begin
        holdoff_q <= 1'b0;
      end
    end
  end

  assign base = VECTOR_BASE_SELECT ? `TLIC_VEC_OFFSET
                                   : `TLIC_PC_W'(APP_START + `TLIC_VEC_OFFSET);

  // program counter load; reset shows the reset address
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      PC_LOAD    <= 1'b1;
      PC_VALUE   <= `TLIC_RESET_PC;
      ACK_VECTOR <= '0;
    end else if (run && state_q == tlic_pkg::TLIC_ST_PUSH && timer_last) begin
      PC_LOAD    <= 1'b1;
      PC_VALUE   <= vec_addr(base, vec_q);
      ACK_VECTOR <= vec_q;
    end else begin
      PC_LOAD <= 1'b0;
    end
  end

  // global enable is an input only and never written back
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      CORE_HOLD    <= 1'b0;
      STACK_PUSH   <= 1'b0;
      STACK_POP    <= 1'b0;
      WAKE_REQUEST <= 1'b0;
    end else begin
      CORE_HOLD    <= (state_d != tlic_pkg::TLIC_ST_IDLE) || DEBUG_HALT;
      STACK_PUSH   <= (state_d == tlic_pkg::TLIC_ST_PUSH);
      STACK_POP    <= (state_d == tlic_pkg::TLIC_ST_POP);
      WAKE_REQUEST <= SLEEPING && any_win;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      NMI_EXEC    <= 1'b0;
      LEVEL1_EXEC <= 1'b0;
      LEVEL0_EXEC <= 1'b0;
    end else begin
      NMI_EXEC    <= exec_q.nmi;
      LEVEL1_EXEC <= exec_q.lvl1;
      LEVEL0_EXEC <= exec_q.normal_priority_level;
    end
  end

endmodule : tlic_core_request_arbiter

`default_nettype wire

// File: tlic_monitor.sv
// tlic_monitor.sv: timing checks on the controller top ports
// assumes: bound to tlic_core_request_arbiter, one MCLK domain
`timescale 1ns/10ps
`default_nettype none
`include "tlic_defs.svh"

module tlic_monitor #(
  parameter bit WIDE_PC = 1'b0
) (
  input wire logic                   MCLK,
  input wire logic                   RST_B,
  input wire logic                   PC_LOAD,
  input wire logic                   CORE_HOLD,
  input wire logic                   STACK_PUSH,
  input wire logic                   STACK_POP,
  input wire logic                   DEBUG_HALT,
  input wire logic                   LEVEL1_EXEC,
  input wire logic                   COMPACT_TABLE_ENABLE,
  input wire logic [`TLIC_VEC_W-1:0] ACK_VECTOR,
  input wire logic [`TLIC_VEC_W-1:0] HIGH_LEVEL_VECTOR
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  a_push_two: assert property (
    $rose(STACK_PUSH) |=> STACK_PUSH ##1 !STACK_PUSH) else $error("push span wrong");
  a_load_after_push: assert property (
    $fell(STACK_PUSH) |-> PC_LOAD) else $error("no load after push");
  a_jump_three: assert property (
    $rose(PC_LOAD) |-> CORE_HOLD[*3] ##1 !CORE_HOLD) else $error("jump span wrong");
  a_pop_span: assert property (
    $rose(STACK_POP) |-> STACK_POP[*4] ##1 (STACK_POP == WIDE_PC) ##1 !STACK_POP)
    else $error("pop span wrong");
  a_one_vector: assert property (
    $rose(PC_LOAD) |=> !PC_LOAD[*6]) else $error("second load too soon");
  a_level1_vec: assert property (
    $rose(LEVEL1_EXEC) |-> ACK_VECTOR ==
      (COMPACT_TABLE_ENABLE ? `TLIC_CVT_L1_VEC : HIGH_LEVEL_VECTOR))
    else $error("level 1 vector wrong");
  a_debug_hold: assert property (
    DEBUG_HALT |=> CORE_HOLD) else $error("core not held in debug");
  a_debug_freeze: assert property (
    DEBUG_HALT[*2] |-> !$rose(STACK_PUSH) && !$rose(PC_LOAD))
    else $error("entry started in debug halt");

  cover property ($rose(LEVEL1_EXEC));
  cover property ($rose(STACK_POP));
  cover property (DEBUG_HALT[*2]);
endmodule : tlic_monitor

bind tlic_core_request_arbiter tlic_monitor #(.WIDE_PC(WIDE_PC)) mon_u (
  .MCLK(MCLK),
  .RST_B(RST_B),
  .PC_LOAD(PC_LOAD),
  .CORE_HOLD(CORE_HOLD),
  .STACK_PUSH(STACK_PUSH),
  .STACK_POP(STACK_POP),
  .DEBUG_HALT(DEBUG_HALT),
  .LEVEL1_EXEC(LEVEL1_EXEC),
  .COMPACT_TABLE_ENABLE(COMPACT_TABLE_ENABLE),
  .ACK_VECTOR(ACK_VECTOR),
  .HIGH_LEVEL_VECTOR(HIGH_LEVEL_VECTOR)
);
`default_nettype wire

// File: tlic_core_model.sv
// tlic_core_model.sv: core stand-in giving instruction boundaries
// assumes: step_len cycles per instruction, count cleared to zero when held or asleep
`timescale 1ns/10ps
`default_nettype none

module tlic_core_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       hold,
  input  wire logic       asleep,
  input  wire logic [3:0] step_len,
  output logic            instr_done
);
  logic [3:0] cnt_q;

  // boundary only once the whole instruction is through
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q      <= 4'h0;
      instr_done <= 1'b0;
    end else if (hold || asleep) begin
      cnt_q      <= 4'h0;
      instr_done <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q + 4'h1 >= step_len) ? 4'h0 : cnt_q + 4'h1;
      instr_done <= (cnt_q + 4'h1 >= step_len);
    end
  end
endmodule : tlic_core_model
`default_nettype wire

// File: tb_top.sv
// tb_top.sv: scenario bench for the interrupt controller
// assumes: package, monitor and core model compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "tlic_defs.svh"
`define CHK(a, b) begin \
  cmp_count++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("unexpected at %0t got %h expected %h", $time, (a), (b)); \
  end \
end

module tb_top;
  localparam logic [15:0] APP = 16'h0400;
  logic        MCLK = 1'b0;
  logic        RST_B = 1'b0;
  logic [15:0] flags = 16'h0000;
  logic [15:0] ctrl = 16'h0000;
  logic [15:0] pv;
  logic [7:0]  ackv;
  logic [7:0]  hlv = 8'h00;
  logic [3:0]  step = 4'h1;
  logic        nmi, ge, rfh, slp, sdone, dbg, vbs, compact_table_enable, rot;
  logic        pl, hold, push, pop, wake, nmx, l1x, l0x, idone, seen;
  int          failures = 0;
  int          cmp_count = 0;
  int          w;
  int          n;

  always #2.5 MCLK = ~MCLK;

  tlic_core_request_arbiter #(.WIDE_PC(1'b0)) dut_u (
    .MCLK(MCLK),
    .RST_B(RST_B),
    .PERIPHERAL_REQUEST_FLAGS(flags),
    .PERIPHERAL_REQUEST_CONTROL(ctrl),
    .NMI_REQUEST(nmi),
    .GLOBAL_ENABLE(ge),
    .INSTR_DONE(idone),
    .RETURN_FROM_HANDLER(rfh),
    .SLEEPING(slp),
    .STARTUP_DONE(sdone),
    .DEBUG_HALT(dbg),
    .VECTOR_BASE_SELECT(vbs),
    .COMPACT_TABLE_ENABLE(compact_table_enable),
    .ROTATING_PRIORITY_ENABLE(rot),
    .HIGH_LEVEL_VECTOR(hlv),
    .APP_START(APP),
    .PC_LOAD(pl),
    .PC_VALUE(pv),
    .CORE_HOLD(hold),
    .STACK_PUSH(push),
    .STACK_POP(pop),
    .WAKE_REQUEST(wake),
    .ACK_VECTOR(ackv),
    .NMI_EXEC(nmx),
    .LEVEL1_EXEC(l1x),
    .LEVEL0_EXEC(l0x)
  );

  tlic_core_model core_u (
    .clk(MCLK),
    .rst_b(RST_B),
    .hold(hold),
    .asleep(slp),
    .step_len(step),
    .instr_done(idone)
  );

  task automatic quiet(input int k);
    seen = 1'b0;
    repeat (k) begin
      @(negedge MCLK);
      seen = seen | pl;
    end
  endtask : quiet

  task automatic take(input logic [7:0] v, input logic [15:0] pc, input logic [2:0] lv);
    w = 0;
    do begin
      @(negedge MCLK);
      w++;
    end while (!pl && w < 80);
    `CHK(pl, 1'b1)
    `CHK(ackv, v)
    `CHK(pv, pc)
    @(negedge MCLK);
    `CHK({nmx, l1x, l0x}, lv)
    repeat (3) @(negedge MCLK);
  endtask : take

  task automatic ret(input logic [2:0] lv);
    @(posedge MCLK);
    rfh <= 1'b1;
    @(posedge MCLK);
    rfh <= 1'b0;
    repeat (7) @(negedge MCLK);
    `CHK({nmx, l1x, l0x}, lv)
  endtask : ret

  task automatic drop_flags;
    @(posedge MCLK);
    flags <= 16'h0000;
  endtask : drop_flags

  task automatic t_fixed;
    @(posedge MCLK);
    ctrl <= 16'h0220;
    flags <= 16'h0228;
    @(posedge MCLK);
    ge <= 1'b1;
    take(8'h07, APP + 16'h000e, 3'b001);
    `CHK(w >= 6, 1'b1)
    drop_flags();
    ret(3'b000);
    $display("test fixed done");
  endtask : t_fixed

  task automatic t_mask;
    @(posedge MCLK);
    ge <= 1'b0;
    flags <= 16'h0020;
    quiet(20);
    `CHK(seen, 1'b0)
    @(posedge MCLK);
    nmi <= 1'b1;
    take(8'h01, APP + 16'h0002, 3'b100);
    @(posedge MCLK);
    nmi <= 1'b0;
    ret(3'b000);
    @(posedge MCLK);
    ge <= 1'b1;
    take(8'h07, APP + 16'h000e, 3'b001);
    drop_flags();
    ret(3'b000);
    $display("test mask done");
  endtask : t_mask

  task automatic t_preempt;
    @(posedge MCLK);
    vbs <= 1'b1;
    hlv <= 8'h0b;
    flags <= 16'h0020;
    take(8'h07, 16'h000e, 3'b001);
    @(posedge MCLK);
    flags <= 16'h0220;
    take(8'h0b, 16'h0016, 3'b011);
    @(posedge MCLK);
    flags <= 16'h0020;
    ret(3'b001);
    drop_flags();
    ret(3'b000);
    @(posedge MCLK);
    vbs <= 1'b0;
    hlv <= 8'h00;
    $display("test preempt done");
  endtask : t_preempt

  task automatic t_robin;
    @(posedge MCLK);
    rot <= 1'b1;
    ctrl <= 16'h0014;
    flags <= 16'h0014;
    take(8'h04, APP + 16'h0008, 3'b001);
    @(posedge MCLK);
    step <= 4'h8;
    ret(3'b000);
    take(8'h06, APP + 16'h000c, 3'b001);
    `CHK(w > 8, 1'b1)
    @(posedge MCLK);
    step <= 4'h1;
    ret(3'b000);
    take(8'h04, APP + 16'h0008, 3'b001);
    drop_flags();
    ret(3'b000);
    @(posedge MCLK);
    rot <= 1'b0;
    ctrl <= 16'h0220;
    $display("test robin done");
  endtask : t_robin

  task automatic t_sleep;
    @(posedge MCLK);
    slp <= 1'b1;
    repeat (2) @(posedge MCLK);
    flags <= 16'h0020;
    repeat (4) @(negedge MCLK);
    `CHK(wake, 1'b1)
    `CHK(push, 1'b0)
    @(posedge MCLK);
    sdone <= 1'b1;
    n = 0;
    do begin
      @(negedge MCLK);
      n++;
    end while (!push && n < 20);
    `CHK((n >= 7) && (n <= 9), 1'b1)
    take(8'h07, APP + 16'h000e, 3'b001);
    @(posedge MCLK);
    slp <= 1'b0;
    sdone <= 1'b0;
    flags <= 16'h0000;
    ret(3'b000);
    $display("test sleep done");
  endtask : t_sleep

  task automatic t_debug;
    @(posedge MCLK);
    ge <= 1'b0;
    dbg <= 1'b1;
    flags <= 16'h0020;
    @(posedge MCLK);
    ge <= 1'b1;
    quiet(10);
    `CHK(seen, 1'b0)
    `CHK(hold, 1'b1)
    @(posedge MCLK);
    dbg <= 1'b0;
    take(8'h07, APP + 16'h000e, 3'b001);
    drop_flags();
    ret(3'b000);
    $display("test debug done");
  endtask : t_debug

  task automatic t_compact;
    @(posedge MCLK);
    compact_table_enable <= 1'b1;
    hlv <= 8'h0b;
    flags <= 16'h0220;
    take(8'h02, APP + 16'h0004, 3'b010);
    @(posedge MCLK);
    flags <= 16'h0020;
    ret(3'b000);
    take(8'h03, APP + 16'h0006, 3'b001);
    drop_flags();
    ret(3'b000);
    @(posedge MCLK);
    compact_table_enable <= 1'b0;
    hlv <= 8'h00;
    $display("test compact done");
  endtask : t_compact

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  initial begin
    {nmi, ge, rfh, slp, sdone, dbg, vbs, compact_table_enable, rot} = 9'h000;
    repeat (10) @(posedge MCLK);
    `CHK(pl, 1'b1)
    `CHK(pv, 16'h0000)
    RST_B <= 1'b1;
    repeat (2) @(negedge MCLK);
    `CHK({nmx, l1x, l0x}, 3'b000)
    t_fixed();
    t_mask();
    t_preempt();
    t_robin();
    t_sleep();
    t_debug();
    t_compact();
    summarize();
  end

  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge MCLK);
    failures++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
